/* rtl/cacr_params.svh */
`ifndef CACR_PARAMS_SVH
`define CACR_PARAMS_SVH

`define CACR_ADDR_CNT_LO   8'hf9
`define CACR_ADDR_CNT_HI   8'hfa
`define CACR_ADDR_CAP0_LO  8'hfb
`define CACR_ADDR_CAP0_HI  8'hfc
`define CACR_ADDR_CAP1_LO  8'he9
`define CACR_ADDR_CAP1_HI  8'hea
`define CACR_ADDR_CAP2_LO  8'heb
`define CACR_ADDR_CAP2_HI  8'hec
`define CACR_ADDR_MODE0    8'hda
`define CACR_ADDR_MODE1    8'hdb
`define CACR_ADDR_MODE2    8'hdc

`define CACR_CMP_EN_BIT    6
`define CACR_WDOG_MODULE   2

`define CACR_RST_BYTE      8'h00
`define CACR_RST_WORD      16'h0000
`define CACR_UNMAPPED_RD   8'h00

`endif

/* rtl/cacr_pkg.sv */
package cacr_pkg;

  localparam int NUM_MODULES = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cacr_sfr_req_t;

  typedef struct packed {
    logic [15:0]                  counter;
    logic [7:0]                   snap;
    logic [NUM_MODULES-1:0][15:0] cap;
    logic [NUM_MODULES-1:0][7:0]  mode;
    logic [7:0]                   rdata;
  } cacr_state_t;

endpackage : cacr_pkg

/* rtl/cacr_top.sv */
// Notes on behaviour
// - Counter bits 7:0 are a read/write byte at address 0xF9.
// - Counter bits 15:8 are a read/write byte at address 0xFA.
// - High byte reads return a snapshot loaded only on low byte reads.
// - Low byte writes are dropped while the watchdog is enabled.
// - High byte writes are dropped while the watchdog is enabled.
// - Three 16-bit capture values; low bytes at 0xFB, 0xE9, 0xEB.
// - Capture high bytes sit at 0xFC, 0xEA, 0xEC.
// - Writing a capture low byte clears that module's compare enable.
// - Writing a capture high byte sets that module's compare enable.
// - Watchdog enabled: module 2 mode register cannot be modified.
// - Mode bit 6 is the compare enable touched by capture writes.
`timescale 1ns/1ps
`include "cacr_params.svh"

module cacr_top (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire cacr_pkg::cacr_sfr_req_t sfr_req,
  input  wire logic                  watchdog_enable_bit,
  input  wire logic                  count_tick,
  output logic [7:0]                 sfr_rdata,
  output logic [15:0]                counter_value,
  output logic [2:0][15:0]           module_capture_value,
  output logic [2:0][7:0]            module_mode,
  output logic [2:0]                 compare_function_enable
);

  localparam int NM = cacr_pkg::NUM_MODULES;
  localparam int CB = `CACR_CMP_EN_BIT;
  localparam int WM = `CACR_WDOG_MODULE;

  localparam logic [NM-1:0][7:0] CAP_LO_ADDR = {
    `CACR_ADDR_CAP2_LO, `CACR_ADDR_CAP1_LO, `CACR_ADDR_CAP0_LO};
  localparam logic [NM-1:0][7:0] CAP_HI_ADDR = {
    `CACR_ADDR_CAP2_HI, `CACR_ADDR_CAP1_HI, `CACR_ADDR_CAP0_HI};
  localparam logic [NM-1:0][7:0] MODE_ADDR = {
    `CACR_ADDR_MODE2, `CACR_ADDR_MODE1, `CACR_ADDR_MODE0};

  cacr_pkg::cacr_state_t state_q;
  cacr_pkg::cacr_state_t state_d;

  function automatic logic wr_hit(input cacr_pkg::cacr_sfr_req_t r,
                                  input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  function automatic logic rd_hit(input cacr_pkg::cacr_sfr_req_t r,
                                  input logic [7:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction : rd_hit

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    // Count first so a software load in the same cycle takes priority
    if (count_tick) begin
      state_d.counter = state_q.counter + 16'h0001;
    end
    if (wr_hit(sfr_req, `CACR_ADDR_CNT_LO) && !watchdog_enable_bit) begin
      state_d.counter[7:0] = sfr_req.wdata;
    end
    if (wr_hit(sfr_req, `CACR_ADDR_CNT_HI) && !watchdog_enable_bit) begin
      state_d.counter[15:8] = sfr_req.wdata;
    end
    // Snapshot keeps a 16-bit read coherent across two byte reads
    if (rd_hit(sfr_req, `CACR_ADDR_CNT_LO)) begin
      state_d.snap = state_q.counter[15:8];
    end
    for (int m = 0; m < NM; m++) begin
      if (wr_hit(sfr_req, MODE_ADDR[m])
          && !(m == WM && watchdog_enable_bit)) begin
        state_d.mode[m] = sfr_req.wdata;
      end
      if (wr_hit(sfr_req, CAP_LO_ADDR[m])) begin
        state_d.cap[m][7:0] = sfr_req.wdata;
        // Watchdog lock also shields module 2 from the side effect
        if (!(m == WM && watchdog_enable_bit)) begin
          state_d.mode[m][CB] = 1'b0;
        end
      end
      if (wr_hit(sfr_req, CAP_HI_ADDR[m])) begin
        state_d.cap[m][15:8] = sfr_req.wdata;
        if (!(m == WM && watchdog_enable_bit)) begin
          state_d.mode[m][CB] = 1'b1;
        end
      end
    end
    if (sfr_req.rd) begin
      state_d.rdata = `CACR_UNMAPPED_RD;
      case (sfr_req.addr)
        `CACR_ADDR_CNT_LO: state_d.rdata = state_q.counter[7:0];
        `CACR_ADDR_CNT_HI: state_d.rdata = state_q.snap;
        default: begin
          for (int m = 0; m < NM; m++) begin
            if (sfr_req.addr == CAP_LO_ADDR[m]) begin
              state_d.rdata = state_q.cap[m][7:0];
            end
            if (sfr_req.addr == CAP_HI_ADDR[m]) begin
              state_d.rdata = state_q.cap[m][15:8];
            end
            if (sfr_req.addr == MODE_ADDR[m]) begin
              state_d.rdata = state_q.mode[m];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q.counter <= `CACR_RST_WORD;
      state_q.snap    <= `CACR_RST_BYTE;
      state_q.cap     <= {NM{`CACR_RST_WORD}};
      state_q.mode    <= {NM{`CACR_RST_BYTE}};
      state_q.rdata   <= `CACR_RST_BYTE;
    end else begin
      state_q <= state_d;
    end
  end

  assign sfr_rdata            = state_q.rdata;
  assign counter_value        = state_q.counter;
  assign module_capture_value = state_q.cap;
  assign module_mode          = state_q.mode;

  always_comb begin
    for (int m = 0; m < NM; m++) begin
      compare_function_enable[m] = state_q.mode[m][CB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_low_read;
    rd_hit(sfr_req, `CACR_ADDR_CNT_LO);
  endsequence

  sequence s_high_read;
    rd_hit(sfr_req, `CACR_ADDR_CNT_HI) && !sfr_req.wr;
  endsequence

  sequence s_locked_write;
    watchdog_enable_bit && !count_tick
    && (wr_hit(sfr_req, `CACR_ADDR_CNT_LO)
        || wr_hit(sfr_req, `CACR_ADDR_CNT_HI));
  endsequence

  a_low_read_data: assert property (
    s_low_read |=> sfr_rdata == $past(counter_value[7:0]))
    else $error("low byte read returned wrong data");

  a_snap_then_high: assert property (
    s_low_read ##1 s_high_read
    |=> sfr_rdata == $past(counter_value[15:8], 2))
    else $error("high byte read not matching snapshot");

  a_snap_hold: assert property (
    !rd_hit(sfr_req, `CACR_ADDR_CNT_LO) |=> $stable(state_q.snap))
    else $error("snapshot changed without low byte read");

  // High byte reads never see the live count, only the held copy
  a_high_read_snap: assert property (
    rd_hit(sfr_req, `CACR_ADDR_CNT_HI) |=> sfr_rdata == $past(state_q.snap))
    else $error("high byte read bypassed the snapshot");

  a_counter_lock: assert property (
    s_locked_write |=> $stable(counter_value))
    else $error("counter changed by locked write");

  a_high_write: assert property (
    wr_hit(sfr_req, `CACR_ADDR_CNT_HI) && !watchdog_enable_bit
    |=> counter_value[15:8] == $past(sfr_req.wdata))
    else $error("unlocked high byte write lost");

  a_low_write: assert property (
    wr_hit(sfr_req, `CACR_ADDR_CNT_LO) && !watchdog_enable_bit
    |=> counter_value[7:0] == $past(sfr_req.wdata))
    else $error("unlocked low byte write lost");

  a_count_step: assert property (
    count_tick && !sfr_req.wr
    |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("counter did not advance on tick");

  a_mode2_lock: assert property (
    watchdog_enable_bit |=> $stable(module_mode[WM]))
    else $error("module 2 mode changed while watchdog on");

  for (genvar g = 0; g < NM; g++) begin : g_chk
    a_cap_low_clr: assert property (
      wr_hit(sfr_req, CAP_LO_ADDR[g])
      && !(g == WM && watchdog_enable_bit)
      |=> !compare_function_enable[g]
          && module_capture_value[g][7:0] == $past(sfr_req.wdata))
      else $error("capture low write did not clear compare enable");

    a_cap_high_set: assert property (
      wr_hit(sfr_req, CAP_HI_ADDR[g])
      && !(g == WM && watchdog_enable_bit)
      |=> compare_function_enable[g]
          && module_capture_value[g][15:8] == $past(sfr_req.wdata))
      else $error("capture high write did not set compare enable");

    // Reads return the byte held before this cycle
    a_cap_low_read: assert property (
      rd_hit(sfr_req, CAP_LO_ADDR[g])
      |=> sfr_rdata == $past(module_capture_value[g][7:0]))
      else $error("capture low read returned wrong data");

    a_cap_high_read: assert property (
      rd_hit(sfr_req, CAP_HI_ADDR[g])
      |=> sfr_rdata == $past(module_capture_value[g][15:8]))
      else $error("capture high read returned wrong data");
  end

endmodule : cacr_top

/* verification/counter_array_capture_regs_bench.sv */
`timescale 1ns/1ps
module counter_array_capture_regs_bench;
  logic                    core_clk = 1'b0;
  logic                    rst_b    = 1'b0;
  cacr_pkg::cacr_sfr_req_t req      = '0;
  logic                    wde      = 1'b0;
  logic                    tick     = 1'b0;
  logic [7:0]              rdata;
  logic [15:0]             cnt_o;
  logic [2:0][15:0]        cap_o;
  logic [2:0][7:0]         mode_o;
  logic [2:0]              cfe_o;
  logic [15:0]             cnt      = 16'h0000;
  logic [15:0]             lfsr     = 16'h6eff;
  logic [7:0]              snap     = 8'h00;
  logic [7:0]              exp_rd   = 8'h00;
  logic [2:0][15:0]        cap      = '0;
  logic [2:0][7:0]         mode     = '0;
  int                      fails    = 0;
  int                      checks_done = 0;
  logic [7:0] addrs [13] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'he9, 8'hea,
                             8'heb, 8'hec, 8'hda, 8'hdb, 8'hdc, 8'h00, 8'hf0};
  logic [7:0] lo_a [3] = '{8'hfb, 8'he9, 8'heb};
  logic [7:0] hi_a [3] = '{8'hfc, 8'hea, 8'hec};
  logic [7:0] md_a [3] = '{8'hda, 8'hdb, 8'hdc};

  always #5 core_clk = ~core_clk;

  cacr_top cacr_top_inst (
    .core_clk                (core_clk),
    .rst_b                   (rst_b),
    .sfr_req                 (req),
    .watchdog_enable_bit     (wde),
    .count_tick              (tick),
    .sfr_rdata               (rdata),
    .counter_value           (cnt_o),
    .module_capture_value    (cap_o),
    .module_mode             (mode_o),
    .compare_function_enable (cfe_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  function logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function logic [7:0] rd_model(input logic [7:0] a);
    case (a)
      8'hf9:   rd_model = cnt[7:0];
      8'hfa:   rd_model = snap;
      8'hfb:   rd_model = cap[0][7:0];
      8'hfc:   rd_model = cap[0][15:8];
      8'he9:   rd_model = cap[1][7:0];
      8'hea:   rd_model = cap[1][15:8];
      8'heb:   rd_model = cap[2][7:0];
      8'hec:   rd_model = cap[2][15:8];
      8'hda:   rd_model = mode[0];
      8'hdb:   rd_model = mode[1];
      8'hdc:   rd_model = mode[2];
      default: rd_model = 8'h00;
    endcase
  endfunction : rd_model

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // One cycle of stimulus; the model advances as the next edge will
  task step(input logic [7:0] a, input logic w, input logic r,
            input logic [7:0] d, input logic t, input logic wd);
    int m;
    @(negedge core_clk);
    req.addr  = a;
    req.wr    = w;
    req.rd    = r;
    req.wdata = d;
    tick      = t;
    wde       = wd;
    if (r) exp_rd = rd_model(a);
    if (r && a == 8'hf9) snap = cnt[15:8];
    cnt = cnt + {15'h0000, t};
    if (w && !wd && a == 8'hf9) cnt[7:0] = d;
    if (w && !wd && a == 8'hfa) cnt[15:8] = d;
    for (m = 0; m < 3; m++) begin
      if (w && a == md_a[m] && !(wd && m == 2)) mode[m] = d;
      if (w && a == lo_a[m]) begin
        cap[m][7:0] = d;
        if (!(wd && m == 2)) mode[m][6] = 1'b0;
      end
      if (w && a == hi_a[m]) begin
        cap[m][15:8] = d;
        if (!(wd && m == 2)) mode[m][6] = 1'b1;
      end
    end
    @(posedge core_clk);
    #1;
    check(cnt_o, cnt);
    check(rdata, exp_rd);
    check(cap_o, cap);
    check(mode_o, mode);
    check(cfe_o, {mode[2][6], mode[1][6], mode[0][6]});
  endtask : step

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    check({cnt_o, rdata, mode_o, cfe_o}, 51'h0);
    check(cap_o, 48'h0);
    step(8'hfa, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    step(8'hf9, 1'b1, 1'b0, 8'hff, 1'b1, 1'b0);
    step(8'hfa, 1'b1, 1'b0, 8'h12, 1'b1, 1'b0);
    step(8'hf9, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0);
    step(8'hfa, 1'b1, 1'b1, 8'h55, 1'b1, 1'b1);
    step(8'hf9, 1'b1, 1'b0, 8'h77, 1'b0, 1'b1);
    step(8'hec, 1'b1, 1'b0, 8'h3c, 1'b0, 1'b1);
    step(8'hdc, 1'b1, 1'b0, 8'hff, 1'b0, 1'b1);
    step(8'hec, 1'b1, 1'b0, 8'h3c, 1'b0, 1'b0);
    step(8'heb, 1'b1, 1'b1, 8'ha5, 1'b0, 1'b0);
    // Low read then high read across a carry shows the held high byte
    step(8'hf9, 1'b1, 1'b0, 8'hff, 1'b0, 1'b0);
    step(8'hf9, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0);
    step(8'hfa, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    // Async reset mid-run must clear all state with no clock edge
    @(negedge core_clk);
    rst_b = 1'b0;
    req   = '0;
    tick  = 1'b0;
    wde   = 1'b0;
    #1;
    check({cnt_o, rdata, mode_o, cfe_o}, 51'h0);
    check(cap_o, 48'h0);
    cnt    = 16'h0000;
    snap   = 8'h00;
    exp_rd = 8'h00;
    cap    = '0;
    mode   = '0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    step(8'hfa, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    // Random mix keeps watchdog on about a quarter of the time
    repeat (3000) begin
      lfsr = lfsr_next(lfsr);
      step(addrs[int'(lfsr[3:0]) % 13], lfsr[4], lfsr[5], lfsr[15:8],
           lfsr[6], lfsr[7] & lfsr[8]);
    end
    step(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    wrap_up();
  end

  // Run needs about 30 us
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule : counter_array_capture_regs_bench
